/* include/timer8_pkg.sv */
/*
 * package for the 8-bit timer/counter with shared prescaler:
 * register offsets, field positions, reset values, phase states.
 * assumes one 25 MHz core clock; four clocks make one instruction cycle.
 */
package timer8_pkg;

	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned PHASES_PER_CYCLE = 4;
	localparam int unsigned WRITE_HOLDOFF_CYCLES = 2;
	localparam logic [3:0] WRITE_HOLDOFF_CLKS = 4'(WRITE_HOLDOFF_CYCLES * PHASES_PER_CYCLE);

	localparam logic [3:0] ADDR_TIMER_COUNT = 4'h0;
	localparam logic [3:0] ADDR_OPTION_CONTROL = 4'h1;
	localparam logic [3:0] ADDR_INTERRUPT_CONTROL = 4'h2;
	localparam logic [3:0] ADDR_EVENT_STATUS = 4'h3;
	localparam logic [3:0] ADDR_EVENT_CLEAR = 4'h4;
	localparam logic [3:0] ADDR_EVENT_ENABLE = 4'h5;

	localparam logic [7:0] OPTION_RESET = 8'hff;
	localparam logic [7:0] INTCTL_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] EVENT_ENABLE_RESET = 8'h00;

	localparam int unsigned OPT_CLOCK_SOURCE_BIT = 5;
	localparam int unsigned OPT_EDGE_SELECT_BIT = 4;
	localparam int unsigned OPT_ASSIGN_BIT = 3;
	localparam int unsigned INT_ENABLE_BIT = 5;
	localparam int unsigned INT_FLAG_BIT = 2;
	localparam int unsigned EVT_OVERFLOW_BIT = 0;
	localparam int unsigned EVT_WATCHDOG_TICK_BIT = 1;

	typedef enum logic [3:0] {
		PHASE_ONE   = 4'h1,
		PHASE_TWO   = 4'h2,
		PHASE_THREE = 4'h4,
		PHASE_FOUR  = 4'h8
	} phase_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} busReq_t;

	typedef struct packed {
		logic       clockSource;
		logic       edgeSelect;
		logic       prescalerAssign;
		logic [2:0] prescaleRate;
	} optionFields_t;

endpackage

/* rtl/prescaler8.sv */
/*
 * 8-bit ripple-free prescaler shared by timer and watchdog.
 * assumes tick is a one-clock pulse and clear wins over tick.
 */
`timescale 1ns/1ps
`default_nettype none
module prescaler8
	import timer8_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       tick,
	input  wire logic       clear,
	input  wire logic       timerOwns,
	input  wire logic [2:0] rate,
	output logic            pulse
);
	logic [7:0] countFf;
	logic [7:0] nxtCount;
	logic [3:0] shiftAmount;
	logic [7:0] limitMask;
	wire        atLimit;

	// divide by 2^(rate+1) for timer, 2^rate for watchdog  [R8]
	assign shiftAmount = timerOwns ? {1'b0, rate} + 4'h1 : {1'b0, rate};
	assign limitMask = 8'((9'h001 << shiftAmount) - 9'h001);
	assign atLimit = (countFf & limitMask) == limitMask;
	assign nxtCount = clear ? 8'h00 : (tick ? (atLimit ? 8'h00 : countFf + 8'h01) : countFf);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			countFf <= 8'h00;
			pulse <= 1'b0;
		end else begin
			countFf <= nxtCount;
			pulse <= tick & ~clear & atLimit;
		end
	end
endmodule
`default_nettype wire

/* rtl/timer8_shared_prescaler.sv */
/*
 * 8-bit timer/counter with prescaler shared with the watchdog, plus
 * option, interrupt control, and sticky event status registers.
 * assumes a plain strobe register port, synchronous pin inputs,
 * and a core that drives sleep and the watchdog clear pulse.
 */
// The implementer's own choices: the strobed register port and the address map.
// Operation
// R1: clock source 0 selects timer mode, one count per instruction cycle.
// R2: after a count write, counting pauses exactly two instruction cycles.
// R3: clock source 1 counts external input edges, edge chosen by edge select.
// R4: edge select 1 counts falling edges, 0 counts rising edges.
// R5: external edges are sampled on phase two and phase four.
// R6: prescaler goes to timer when assign bit is 0, else watchdog.
// R7: timer prescale field picks eight ratios from 1:2 to 1:256.
// R8: timer ratio is 2^(rate+1); watchdog ratio is 2^rate.
// R9: timer runs 1:1 only while prescaler belongs to watchdog.
// R10: software cannot read or write the prescaler counter.
// R11: count writes clear prescaler while timer owns it.
// R12: watchdog clear instruction clears prescaler while watchdog owns it.
// R13: software sequence for moving prescaler from timer to watchdog.
// R14: software sequence for moving prescaler from watchdog to timer.
// R15: every wrap from FFh to 00h sets the overflow flag.
// R16: software clears the overflow flag; hardware never does.
// R17: overflow enable gates the flag onto the interrupt request.
// R18: during sleep the timer stops counting entirely.
`timescale 1ns/1ps
`default_nettype none
module timer8_shared_prescaler
	import timer8_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       externalCountInput,
	input  wire logic       sleep,
	input  wire logic       watchdogClearInstr,
	input  wire logic       watchdogTick,
	output logic            watchdogPulse,
	output logic            overflowIrq,
	output logic            irq
);
	busReq_t       bus;
	optionFields_t opt;

	phase_t     phaseFf;
	phase_t     nxtPhase;
	logic [7:0] countFf;
	logic [7:0] optionFf;
	logic [7:0] intCtlFf;
	logic [1:0] statusFf;
	logic [1:0] enableFf;
	logic [3:0] holdFf;
	logic       extLevelFf;
	logic       extEdgeFf;
	logic [7:0] nxtCount;
	logic [7:0] nxtIntCtl;
	logic [1:0] nxtStatus;
	logic [7:0] readMux;
	logic       presPulse;

	wire writeCount = bus.wr && bus.addr == ADDR_TIMER_COUNT;
	wire writeOption = bus.wr && bus.addr == ADDR_OPTION_CONTROL;
	wire writeIntCtl = bus.wr && bus.addr == ADDR_INTERRUPT_CONTROL;
	wire writeClear = bus.wr && bus.addr == ADDR_EVENT_CLEAR;
	wire writeEnable = bus.wr && bus.addr == ADDR_EVENT_ENABLE;

	assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
	assign opt = '{clockSource: optionFf[OPT_CLOCK_SOURCE_BIT],
		edgeSelect: optionFf[OPT_EDGE_SELECT_BIT],
		prescalerAssign: optionFf[OPT_ASSIGN_BIT],
		prescaleRate: optionFf[2:0]};

	// timer owns the prescaler only with the assign bit clear  [R6]
	wire timerOwns = ~opt.prescalerAssign;
	wire cycleEnd = phaseFf == PHASE_FOUR;
	wire sampleTick = (phaseFf == PHASE_TWO) || (phaseFf == PHASE_FOUR);

	// edge select 1 is falling, 0 is rising  [R3] [R4]
	wire extEdge = opt.edgeSelect ? (extLevelFf & ~externalCountInput) : (~extLevelFf & externalCountInput);

	// raw source: instruction cycle or qualified external edge  [R1] [R3] [R5]
	wire sourceTick = opt.clockSource ? (extEdgeFf & sampleTick) : cycleEnd;

	// prescaler input: timer source or watchdog ticks  [R6]
	wire presTick = timerOwns ? sourceTick : watchdogTick;

	// count clears the prescaler when timer owns it, watchdog clear otherwise  [R11] [R12]
	wire presClear = timerOwns ? writeCount : watchdogClearInstr;

	// bypass gives the undivided rate only while watchdog owns prescaler  [R9] [R7]
	wire countTick = timerOwns ? presPulse : sourceTick;

	// frozen in sleep; held off after a write  [R18] [R2]
	wire countEnable = countTick && !sleep && holdFf == 4'h0 && !writeCount;
	wire wrap = countEnable && countFf == 8'hff;

	// the prescaler has no bus path at all  [R10]
	prescaler8 prescaler (
		.clk      (clk),
		.rst      (rst),
		.tick     (presTick),
		.clear    (presClear),
		.timerOwns(timerOwns),
		.rate     (opt.prescaleRate),
		.pulse    (presPulse)
	);

	always_comb begin
		unique case (phaseFf)
			PHASE_ONE:   nxtPhase = PHASE_TWO;
			PHASE_TWO:   nxtPhase = PHASE_THREE;
			PHASE_THREE: nxtPhase = PHASE_FOUR;
			PHASE_FOUR:  nxtPhase = PHASE_ONE;
			default:     nxtPhase = PHASE_ONE;
		endcase
	end

	assign nxtCount = writeCount ? bus.wdata : (countEnable ? countFf + 8'h01 : countFf); // [R1] [R2]

	// set wins over a same-cycle software clear  [R15] [R16]
	always_comb begin
		nxtIntCtl = writeIntCtl ? bus.wdata : intCtlFf;
		if (wrap) begin
			nxtIntCtl[INT_FLAG_BIT] = 1'b1; // [R15]
		end
	end

	always_comb begin
		nxtStatus = writeClear ? (statusFf & ~bus.wdata[1:0]) : statusFf;
		if (wrap) begin
			nxtStatus[EVT_OVERFLOW_BIT] = 1'b1;
		end
		if (presPulse && !timerOwns) begin
			nxtStatus[EVT_WATCHDOG_TICK_BIT] = 1'b1;
		end
	end

	always_comb begin
		unique case (bus.addr)
			ADDR_TIMER_COUNT:       readMux = countFf;
			ADDR_OPTION_CONTROL:    readMux = optionFf;
			ADDR_INTERRUPT_CONTROL: readMux = intCtlFf;
			ADDR_EVENT_STATUS:      readMux = {6'h00, statusFf};
			ADDR_EVENT_ENABLE:      readMux = {6'h00, enableFf};
			default:                readMux = 8'h00;
		endcase
	end

	// hold counts in core clocks; a write at any phase starts a full two cycles  [R2]
	wire [3:0] nxtHold = writeCount ? WRITE_HOLDOFF_CLKS : (holdFf != 4'h0 ? holdFf - 4'h1 : 4'h0);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phaseFf <= PHASE_ONE;
			countFf <= COUNT_RESET;
			optionFf <= OPTION_RESET;
			intCtlFf <= INTCTL_RESET;
			statusFf <= 2'h0;
			enableFf <= EVENT_ENABLE_RESET[1:0];
			holdFf <= 4'h0;
			extLevelFf <= 1'b0;
			extEdgeFf <= 1'b0;
			rdata <= 8'h00;
			watchdogPulse <= 1'b0;
			overflowIrq <= 1'b0;
			irq <= 1'b0;
		end else begin
			phaseFf <= nxtPhase;
			countFf <= nxtCount;
			optionFf <= writeOption ? bus.wdata : optionFf;
			intCtlFf <= nxtIntCtl;
			statusFf <= nxtStatus;
			enableFf <= writeEnable ? bus.wdata[1:0] : enableFf;
			holdFf <= nxtHold;
			extLevelFf <= externalCountInput;
			// edge seen between samples is kept until the next phase-two or phase-four  [R5]
			extEdgeFf <= sampleTick ? extEdge : (extEdgeFf | extEdge);
			rdata <= bus.rd ? readMux : 8'h00;
			watchdogPulse <= presPulse & ~timerOwns;
			overflowIrq <= nxtIntCtl[INT_ENABLE_BIT] & nxtIntCtl[INT_FLAG_BIT]; // [R17]
			irq <= |(nxtStatus & (writeEnable ? bus.wdata[1:0] : enableFf));
		end
	end
endmodule
`default_nettype wire

/* testbench/timer8_shared_prescaler_chk.sv */
/* port checker for the timer, bound to its top module.
   assumes one clock domain and the package offsets. */
`timescale 1ns/1ps
`default_nettype none
module timer8_shared_prescaler_chk
	import timer8_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       watchdogTick,
	input wire logic       watchdogClearInstr,
	input wire logic       watchdogPulse,
	input wire logic       overflowIrq,
	input wire logic       irq
);
	logic [7:0]      opt_ff;
	logic [2:0]      ovEn_ff, evEn_ff;
	wire logic [7:0] nxt_opt = wr && addr == ADDR_OPTION_CONTROL ? wdata : opt_ff;
	wire logic       nxt_ovEn = wr && addr == ADDR_INTERRUPT_CONTROL ? wdata[INT_ENABLE_BIT] : ovEn_ff[0];
	wire logic       nxt_evEn = wr && addr == ADDR_EVENT_ENABLE ? |wdata[1:0] : evEn_ff[0];
	// enables kept three deep: outputs may lag a write by two clocks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			opt_ff <= OPTION_RESET;
			ovEn_ff <= 3'h0;
			evEn_ff <= 3'h0;
		end else begin
			opt_ff <= nxt_opt;
			ovEn_ff <= {ovEn_ff[1:0], nxt_ovEn};
			evEn_ff <= {evEn_ff[1:0], nxt_evEn};
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_pulse;
		##[1:2] watchdogPulse;
	endsequence
	AST_RDATA_IDLE: assert property (!$past(rd) || $past(addr) > ADDR_EVENT_ENABLE |-> rdata == 8'h00)
		else $error("read data not zero");
	AST_OPTION_READ: assert property ($past(rd) && $past(addr) == ADDR_OPTION_CONTROL |-> rdata == $past(opt_ff))
		else $error("option read back wrong");
	AST_TIMER_OWNS: assert property (!opt_ff[OPT_ASSIGN_BIT] && !$past(opt_ff[OPT_ASSIGN_BIT], 2) |-> !watchdogPulse)
		else $error("watchdog pulse while timer owns prescaler");
	AST_OVF_GATED: assert property (ovEn_ff == 3'h0 |-> !overflowIrq)
		else $error("overflow request while disabled");
	AST_IRQ_GATED: assert property (evEn_ff == 3'h0 |-> !irq)
		else $error("interrupt while no event enabled");
	AST_OVF_STICKY: assert property (overflowIrq && !wr && !$past(wr) |=> overflowIrq)
		else $error("overflow request dropped without software");
	AST_IRQ_STICKY: assert property (irq && !wr && !$past(wr) |=> irq)
		else $error("interrupt dropped without software");
	AST_PULSE_CAUSE: assert property (watchdogPulse |-> $past(watchdogTick) || $past(watchdogTick, 2))
		else $error("watchdog pulse without tick");
	AST_WDT_UNDIVIDED: assert property (opt_ff[3:0] == 4'h8 && watchdogTick && !watchdogClearInstr |-> s_pulse)
		else $error("watchdog tick not passed at rate zero");
endmodule
bind timer8_shared_prescaler timer8_shared_prescaler_chk chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .watchdogTick(watchdogTick), .watchdogClearInstr(watchdogClearInstr),
	.watchdogPulse(watchdogPulse), .overflowIrq(overflowIrq), .irq(irq));
`default_nettype wire

/* testbench/count_source_model.sv */
/* external count source: flips its line on request.
   assumes levels of two instruction cycles suffice for sampling. */
`timescale 1ns/1ps
`default_nettype none
module count_source_model (
	input  wire logic clk,
	output var logic  level
);
	initial level = 1'b0;
	// long levels so phase-two and phase-four sampling sees each edge
	task automatic flip(input int n);
		repeat (n) begin
			repeat (8) @(posedge clk);
			level <= ~level;
		end
		repeat (8) @(posedge clk);
	endtask
endmodule
`default_nettype wire

/* testbench/timer8_shared_prescaler_tb.sv */
/* bench: count-rate table, then hold-off, interrupt, pin and watchdog tests.
   assumes the count source model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module timer8_shared_prescaler_tb
	import timer8_pkg::*;
;
	typedef struct packed {logic [7:0] opt; logic slp; logic [11:0] span; logic [7:0] inc;} row_t;
	row_t       rows [10] = '{'{8'h08, 1'h1, 12'h028, 8'h00}, '{8'h08, 1'h0, 12'h028, 8'h0a},
		'{8'h00, 1'h0, 12'h010, 8'h02}, '{8'h01, 1'h0, 12'h020, 8'h02}, '{8'h02, 1'h0, 12'h040, 8'h02},
		'{8'h03, 1'h0, 12'h080, 8'h02}, '{8'h04, 1'h0, 12'h100, 8'h02}, '{8'h05, 1'h0, 12'h200, 8'h02},
		'{8'h06, 1'h0, 12'h400, 8'h02}, '{8'h07, 1'h0, 12'h800, 8'h02}};
	logic       clk, rst = 1'h1, wr = 1'h0, rd = 1'h0, sleep = 1'h0, wdClr = 1'h0, wdTick = 1'h0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata, got, v;
	wire logic  ext, wdPulse, ovIrq, irq;
	int         numErrors = 0, samplesChecked = 0, pulses = 0;
	count_source_model src (.clk(clk), .level(ext));
	timer8_shared_prescaler dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.externalCountInput(ext), .sleep(sleep), .watchdogClearInstr(wdClr), .watchdogTick(wdTick),
		.watchdogPulse(wdPulse), .overflowIrq(ovIrq), .irq(irq));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) if (wdPulse === 1'b1) pulses <= pulses + 1;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		samplesChecked++;
		if (seen !== exp) begin
			numErrors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	// read data only stand in the cycle after the strobe, so sample mid-cycle
	task automatic rdReg(input logic [3:0] a);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		got = rdata;
		@(posedge clk);
	endtask
	task automatic strike(input logic t, input logic c);
		wdTick <= t;
		wdClr <= c;
		@(posedge clk);
		wdTick <= 1'b0;
		wdClr <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic giveVerdict();
		$display("checks %0d errors %0d", samplesChecked, numErrors);
		if (numErrors == 0 && samplesChecked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#1000000;
		numErrors++;
		giveVerdict();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdReg(ADDR_OPTION_CONTROL);
		check(got, OPTION_RESET, "option reset");
		rdReg(4'hf);
		check(got, 8'h00, "unmapped read");
		foreach (rows[i]) begin
			wrReg(ADDR_OPTION_CONTROL, rows[i].opt);
			sleep <= rows[i].slp;
			rdReg(ADDR_TIMER_COUNT);
			v = got;
			repeat (rows[i].span - 2) @(posedge clk);
			rdReg(ADDR_TIMER_COUNT);
			check(got - v, rows[i].inc, "count step");
		end
		wrReg(ADDR_OPTION_CONTROL, 8'h08);
		wrReg(ADDR_TIMER_COUNT, 8'h40);
		repeat (4) @(posedge clk);
		rdReg(ADDR_TIMER_COUNT);
		check(got, 8'h40, "count in hold-off");
		repeat (15) @(posedge clk);
		rdReg(ADDR_TIMER_COUNT);
		check({7'h0, got > 8'h42 && got < 8'h46}, 8'h01, "count after hold-off");
		wrReg(ADDR_OPTION_CONTROL, 8'h07);
		wrReg(ADDR_TIMER_COUNT, 8'h10);
		strike(1'b1, 1'b0);
		repeat (900) @(posedge clk);
		rdReg(ADDR_TIMER_COUNT);
		check(got, 8'h10, "count with cleared prescaler");
		repeat (200) @(posedge clk);
		rdReg(ADDR_TIMER_COUNT);
		check(got, 8'h11, "count after one prescale period");
		// timer to watchdog hand-over: prescaler emptied before the assign bit moves
		strike(1'b0, 1'b1);
		wrReg(ADDR_TIMER_COUNT, 8'h00);
		wrReg(ADDR_OPTION_CONTROL, 8'h0f);
		strike(1'b0, 1'b1);
		wrReg(ADDR_OPTION_CONTROL, 8'h08);
		strike(1'b1, 1'b0);
		wrReg(ADDR_INTERRUPT_CONTROL, 8'h20);
		wrReg(ADDR_EVENT_ENABLE, 8'h01);
		wrReg(ADDR_TIMER_COUNT, 8'hff);
		repeat (20) @(negedge clk);
		check({6'h0, ovIrq, irq}, 8'h03, "interrupt lines");
		wrReg(ADDR_INTERRUPT_CONTROL, 8'h00);
		wrReg(ADDR_EVENT_STATUS, 8'h00);
		rdReg(ADDR_EVENT_STATUS);
		check(got, 8'h03, "status");
		wrReg(ADDR_EVENT_CLEAR, 8'h01);
		@(negedge clk);
		check({6'h0, ovIrq, irq}, 8'h00, "interrupt lines");
		repeat (1100) @(posedge clk);
		rdReg(ADDR_INTERRUPT_CONTROL);
		check(got, 8'h04, "flag without enable");
		for (int k = 0; k < 2; k++) begin
			wrReg(ADDR_OPTION_CONTROL, k ? 8'h38 : 8'h28);
			rdReg(ADDR_TIMER_COUNT);
			v = got;
			src.flip(3);
			rdReg(ADDR_TIMER_COUNT);
			check(got - v, 8'h02, "pin edges");
		end
		wrReg(ADDR_OPTION_CONTROL, 8'h09);
		strike(1'b0, 1'b1);
		v = 8'(pulses);
		strike(1'b1, 1'b0);
		strike(1'b0, 1'b1);
		strike(1'b1, 1'b0);
		check(8'(pulses), v, "watchdog pulses");
		strike(1'b1, 1'b0);
		check(8'(pulses), v + 8'h01, "watchdog pulses");
		// watchdog to timer hand-over, then 1:16 of instruction cycles
		strike(1'b0, 1'b1);
		wrReg(ADDR_OPTION_CONTROL, 8'h03);
		rdReg(ADDR_TIMER_COUNT);
		v = got;
		repeat (126) @(posedge clk);
		rdReg(ADDR_TIMER_COUNT);
		check(got - v, 8'h02, "count after hand-over");
		giveVerdict();
	end
endmodule
`default_nettype wire
